// ### design/rtcai_regs.svh
// register offsets, bit positions, reset values and timing constants of the alarm/periodic interrupt block
// assumes a 50 MHz sys_clk and a one-cycle 32.768 kHz tick from the oscillator domain, already synchronous
`ifndef RTCAI_REGS_SVH
`define RTCAI_REGS_SVH
`define RTCAI_ADDR_CTRL        4'hE
`define RTCAI_ADDR_FLAGS       4'hF
`define RTCAI_CTRL_RESET       8'h00
`define RTCAI_FLAGS_RESET      8'h00
`define RTCAI_BIT_WEN          7
`define RTCAI_BIT_DEN          6
`define RTCAI_BIT_CKDIS_B      4
`define RTCAI_BIT_CKDIS_A      3
`define RTCAI_BIT_PFLAG        2
`define RTCAI_BIT_WFLAG        1
`define RTCAI_BIT_DFLAG        0
`define RTCAI_SEL_MSB          2
`define RTCAI_DIV_W            15
`define RTCAI_DIV_HALF_2HZ     15'h2000
`define RTCAI_DIV_HALF_1HZ     15'h4000
`define RTCAI_DIV_ZERO         15'h0000
`define RTCAI_INC_DELAY_NS     46000
`define RTCAI_CLK_NS           20
`define RTCAI_INC_DELAY_CYC    (`RTCAI_INC_DELAY_NS / `RTCAI_CLK_NS)
`define RTCAI_DLY_W            12
`endif

// ### design/rtcai_pkg.sv
// types shared by the alarm/periodic interrupt block
// assumes rtcai_regs.svh for constants
package rtcai_pkg;
    // periodic selection codes
    typedef enum logic [2:0] {
        RTCAI_SEL_OFF, RTCAI_SEL_LOW, RTCAI_SEL_P2HZ, RTCAI_SEL_P1HZ,
        RTCAI_SEL_LSEC, RTCAI_SEL_LMIN, RTCAI_SEL_LHOUR, RTCAI_SEL_LMONTH
    } rtcai_sel_t;
endpackage

// ### design/rtcai_alarm_cmp.sv
// one alarm comparator with its sticky flag
// assumes the minute tick is one cycle wide and time fields are stable around it
`timescale 1ns/1ps
`include "rtcai_regs.svh"
module rtcai_alarm_cmp
    import rtcai_pkg::*;
(
    input  wire logic       sys_clk,    // system clock
    input  wire logic       rst_n,      // async reset, active low
    input  wire logic       enable,     // alarm enable bit
    input  wire logic       minute_tick,// minute counter just updated
    input  wire logic       match,      // time fields equal alarm fields
    input  wire logic       clear,      // software wrote zero to the flag
    output logic            flag        // sticky alarm flag
);
    typedef struct packed {
        logic flag;                     // sticky flag
    } rtcai_cmp_st_t;
    rtcai_cmp_st_t st_q;
    rtcai_cmp_st_t st_d;

    // evaluate only at the minute update, so enabling onto a match waits for the next minute tick
    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.flag = 1'b0;
        end
        if (enable && minute_tick && match) begin
            st_d.flag = 1'b1;                                     // set wins over clear
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;

    // a match while enabled must raise the flag next edge
    alarm_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (enable && minute_tick && match) |=> flag)
        else $error("alarm match did not set flag");
    // no match tick means no rise
    alarm_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!flag && !(enable && minute_tick && match)) |=> !flag)
        else $error("alarm flag rose without a match tick");
endmodule // rtcai_alarm_cmp

// ### design/rtcai_core.sv
// alarm comparators, periodic interrupt generator and gated 32 kHz output of a real-time clock
// assumes time counters outside; ticks are one-cycle pulses synchronous to sys_clk
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "rtcai_regs.svh"
module rtcai_core
    import rtcai_pkg::*;
(
    input  wire logic       sys_clk,            // 50 MHz system clock
    input  wire logic       rst_n,              // async reset, active low
    input  wire logic [3:0] addr,               // register address
    input  wire logic [7:0] wdata,              // write data
    input  wire logic       wr,                 // write strobe
    input  wire logic       rd,                 // read strobe
    output logic      [7:0] rdata,              // read data, cycle after rd
    input  wire logic       xtal_tick,          // one pulse per 32.768 kHz cycle
    input  wire logic       xtal_level,         // 32.768 kHz level, sampled
    input  wire logic       trim_tick,          // trimming step input, unused: the divider ignores it
    input  wire logic       sec_write,          // host wrote the second counter
    input  wire logic       minute_tick,        // minute counter updated
    input  wire logic [2:0] weekday,            // weekday counter
    input  wire logic [7:0] hour,               // hour counter
    input  wire logic [7:0] minute,             // minute counter
    input  wire logic [7:0] second,             // second counter
    input  wire logic [7:0] day,                // day-of-month counter
    input  wire logic [6:0] walarm_weekdays,    // weekly alarm weekday mask
    input  wire logic [7:0] walarm_hour,        // weekly alarm hour
    input  wire logic [7:0] walarm_minute,      // weekly alarm minute
    input  wire logic [7:0] dalarm_hour,        // daily alarm hour
    input  wire logic [7:0] dalarm_minute,      // daily alarm minute
    input  wire logic       clock_out_gate_pin, // external clock output gate
    output logic            second_inc,         // pulse: advance the second counter
    output logic            primary_irq_n,      // daily alarm or periodic, open drain level
    output logic            primary_irq_oe,     // high while pin pulled low
    output logic            secondary_irq_n,    // weekly alarm, open drain level
    output logic            secondary_irq_oe,   // high while pin pulled low
    output logic            shared_irq_n,       // all three sources on one pin
    output logic            shared_irq_oe,      // high while pin pulled low
    output logic            crystal_clock_output// gated 32.768 kHz clock
);
    typedef struct packed {
        logic [7:0]              ctrl;      // control register
        logic                    pflag;     // periodic flag
        logic                    ckdis_a_n; // clock disable bit in flags register
        logic [7:0]              rdata;     // read data holding
        logic [`RTCAI_DIV_W-1:0] div;       // sub-second divider
        logic                    phase;     // pulse-mode output level, 1 = high
        logic                    inc_pend;  // second increment pending
        logic [`RTCAI_DLY_W-1:0] dly;       // increment delay counter
        logic                    ck_en;     // clock gate, changes on low clock
        logic                    ck_out;    // registered clock output
        logic                    sec_q;     // second_inc register
    } rtcai_st_t;
    rtcai_st_t st_q;
    rtcai_st_t st_d;

    logic       wflag;      // weekly alarm flag
    logic       dflag;      // daily alarm flag
    logic       wmatch;     // weekly fields equal
    logic       dmatch;     // daily fields equal
    logic       wr_flags;   // write to flags register
    logic       wclr;       // weekly flag clear
    logic       dclr;       // daily flag clear
    logic       sec_wrap;   // divider rolls to a new second
    logic       lvl_event;  // selected level-mode event
    logic       per_low;    // periodic source asserted
    rtcai_sel_t sel;        // periodic selection

    assign sel      = rtcai_sel_t'(st_q.ctrl[`RTCAI_SEL_MSB:0]);
    assign wr_flags = wr && (addr == `RTCAI_ADDR_FLAGS);
    assign wclr     = wr_flags && !wdata[`RTCAI_BIT_WFLAG];
    assign dclr     = wr_flags && !wdata[`RTCAI_BIT_DFLAG];
    // weekday mask picks the days, then hour and minute
    assign wmatch   = walarm_weekdays[weekday] && (hour == walarm_hour)
                      && (minute == walarm_minute);
    assign dmatch   = (hour == dalarm_hour) && (minute == dalarm_minute);

    // weekly comparator, enable at control D7
    rtcai_alarm_cmp u_walarm (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .enable      (st_q.ctrl[`RTCAI_BIT_WEN]),
        .minute_tick (minute_tick),
        .match       (wmatch),
        .clear       (wclr),
        .flag        (wflag)
    );
    // daily comparator, enable at control D6
    rtcai_alarm_cmp u_dalarm (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .enable      (st_q.ctrl[`RTCAI_BIT_DEN]),
        .minute_tick (minute_tick),
        .match       (dmatch),
        .clear       (dclr),
        .flag        (dflag)
    );

    // divider boundaries; trim_tick is not used, so the divider counts xtal_tick only
    assign sec_wrap  = xtal_tick && (st_q.div == {`RTCAI_DIV_W{1'b1}});

    // level-mode event decode at the second increment itself
    always_comb begin
        lvl_event = 1'b0;
        unique case (sel)
            RTCAI_SEL_LSEC:   lvl_event = st_q.sec_q;
            RTCAI_SEL_LMIN:   lvl_event = st_q.sec_q && (second == 8'h00);
            RTCAI_SEL_LHOUR:  lvl_event = st_q.sec_q && (second == 8'h00) && (minute == 8'h00);
            RTCAI_SEL_LMONTH: lvl_event = st_q.sec_q && (second == 8'h00) && (minute == 8'h00)
                                          && (hour == 8'h00) && (day == 8'h01);
            RTCAI_SEL_OFF, RTCAI_SEL_LOW, RTCAI_SEL_P2HZ, RTCAI_SEL_P1HZ: lvl_event = 1'b0;
        endcase
    end

    // periodic source level
    always_comb begin
        per_low = 1'b0;
        unique case (sel)
            RTCAI_SEL_OFF:  per_low = 1'b0;
            RTCAI_SEL_LOW:  per_low = 1'b1;
            RTCAI_SEL_P2HZ, RTCAI_SEL_P1HZ: per_low = !st_q.phase;
            RTCAI_SEL_LSEC, RTCAI_SEL_LMIN, RTCAI_SEL_LHOUR, RTCAI_SEL_LMONTH:
                            per_low = st_q.pflag;
        endcase
    end

    // next-state logic for registers, divider, pulse phase and clock gate
    always_comb begin
        st_d       = st_q;
        st_d.sec_q = 1'b0;
        // register writes; enables untouched by flag clears
        if (wr && (addr == `RTCAI_ADDR_CTRL)) begin
            st_d.ctrl = wdata;
        end
        if (wr_flags) begin
            st_d.ckdis_a_n = wdata[`RTCAI_BIT_CKDIS_A];
            if (!wdata[`RTCAI_BIT_PFLAG]) begin
                st_d.pflag = 1'b0;
            end
        end
        // set wins over a clear in the same cycle
        if (lvl_event) begin
            st_d.pflag = 1'b1;
        end
        // read data, unmapped reads give zero
        if (rd) begin
            unique case (addr)
                `RTCAI_ADDR_CTRL:  st_d.rdata = st_q.ctrl;
                `RTCAI_ADDR_FLAGS: st_d.rdata = {4'h0, st_q.ckdis_a_n, st_q.pflag, wflag, dflag};
                default:           st_d.rdata = 8'h00;
            endcase
        end
        // sub-second divider and pulse phase
        if (sec_write) begin
            st_d.div      = `RTCAI_DIV_ZERO;
            st_d.phase    = 1'b0;
            st_d.inc_pend = 1'b0;
        end else if (xtal_tick) begin
            st_d.div = `RTCAI_DIV_W'(st_q.div + 1'b1);
            // phase follows one divider bit, so each period starts low and is half low
            if (sel == RTCAI_SEL_P2HZ) begin
                st_d.phase = |(st_d.div & `RTCAI_DIV_HALF_2HZ);
            end else begin
                st_d.phase = |(st_d.div & `RTCAI_DIV_HALF_1HZ);
            end
            // the wrap to zero is the falling edge of the pulse
            if (sec_wrap) begin
                st_d.inc_pend = 1'b1;
                st_d.dly      = `RTCAI_DLY_W'(`RTCAI_INC_DELAY_CYC);
            end
        end
        // second increment: delayed in pulse mode, two cycles after the wrap in level mode, before the pin falls
        if (st_q.inc_pend && !sec_write) begin
            if ((st_q.dly == '0) || st_q.ctrl[`RTCAI_SEL_MSB]) begin
                st_d.inc_pend = 1'b0;
                st_d.sec_q    = 1'b1;
            end else begin
                st_d.dly = st_q.dly - 1'b1;
            end
        end
        // gate changes only while the clock is low, so no short pulse
        if (!xtal_level) begin
            st_d.ck_en = clock_out_gate_pin &&
                         (!st_q.ckdis_a_n || !st_q.ctrl[`RTCAI_BIT_CKDIS_B]);
        end
        st_d.ck_out = xtal_level && st_d.ck_en;
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= '0;
            st_q.ctrl <= `RTCAI_CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // pins, open drain: oe high while pulling low
    assign primary_irq_oe       = dflag || per_low;
    assign secondary_irq_oe     = wflag;
    assign shared_irq_oe        = wflag || dflag || per_low;
    assign primary_irq_n        = !primary_irq_oe;
    assign secondary_irq_n      = !secondary_irq_oe;
    assign shared_irq_n         = !shared_irq_oe;
    assign rdata                = st_q.rdata;
    assign second_inc           = st_q.sec_q;
    assign crystal_clock_output = st_q.ck_out;

    // weekly flag drives secondary pin low
    weekly_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wflag |-> (!secondary_irq_n && !shared_irq_n))
        else $error("weekly flag without low pin");
    // daily clear by writing zero
    daily_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dclr && !minute_tick) |=> !dflag)
        else $error("daily flag not cleared");
    // clear keeps enables
    enable_kept_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_flags && !(wr && addr == `RTCAI_ADDR_CTRL)) |=> $stable(st_q.ctrl))
        else $error("flag write changed enables");
    // held low code
    sel_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel == RTCAI_SEL_LOW) |-> !primary_irq_n)
        else $error("select one not low");
    // off code with no alarm keeps primary high
    sel_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((sel == RTCAI_SEL_OFF) && !dflag) |-> primary_irq_n)
        else $error("primary low while off");
    // level event sets flag and pin
    level_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lvl_event |=> (st_q.pflag && (!st_q.ctrl[`RTCAI_SEL_MSB] || !primary_irq_n)))
        else $error("level event lost");
    // pulse-mode increment after the delay
    inc_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sec_wrap && !sec_write && (sel == RTCAI_SEL_P1HZ) && $stable(st_q.ctrl))
        |-> ##1 !second_inc [*8])
        else $error("second increment too early");
    // second write zeroes divider and lowers phase
    sec_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sec_write |=> ((st_q.div == `RTCAI_DIV_ZERO) && !st_q.phase))
        else $error("second write did not restart divider");
    // clock out only when gated on
    clk_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crystal_clock_output |-> st_q.ck_en)
        else $error("clock output while gated off");
    // level mode: the second advances two cycles after the wrap, one cycle before the pin falls
    level_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((sec_wrap && !sec_write && st_q.ctrl[`RTCAI_SEL_MSB]) ##1 (st_q.ctrl[`RTCAI_SEL_MSB] && !sec_write))
        |=> second_inc)
        else $error("level-mode second increment late");
    // second write in pulse mode pulls the periodic pin low at once
    sec_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sec_write && !wr && ((sel == RTCAI_SEL_P2HZ) || (sel == RTCAI_SEL_P1HZ))) |=> !primary_irq_n)
        else $error("second write left periodic pin high");
    // clock output edges ride only on crystal edges, so no pulse is cut short
    clk_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(crystal_clock_output) |-> ($past(xtal_level) && !$past(xtal_level, 2)))
        else $error("clock output rose off a crystal edge");
    clk_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(crystal_clock_output) |-> (!$past(xtal_level) && $past(xtal_level, 2)))
        else $error("clock output fell off a crystal edge");
endmodule // rtcai_core

// ### tb/rtcai_host_model.sv
// far side of the interrupt block: fast oscillator source and pulled-up interrupt wires
// assumes the block treats one xtal_tick per sys_clk as a legal, sped-up 32 kHz source
`timescale 1ns/1ps
module rtcai_host_model (
    input  wire logic sys_clk,    // system clock
    input  wire logic rst_n,      // async reset, active low
    input  wire logic prim_oe,    // primary pin pulled low
    input  wire logic sec_oe,     // secondary pin pulled low
    input  wire logic shr_oe,     // shared pin pulled low
    output logic      xtal_tick,  // divider step
    output logic      xtal_level, // slow square wave for clock out
    output logic      prim_pin,   // resolved primary wire
    output logic      sec_pin,    // resolved secondary wire
    output logic      shr_pin     // resolved shared wire
);
    logic [3:0] ph_q; // half period counter of the square wave
    // pull-ups: a released open-drain wire reads high
    assign prim_pin = prim_oe ? 1'b0 : 1'b1;
    assign sec_pin  = sec_oe ? 1'b0 : 1'b1;
    assign shr_pin  = shr_oe ? 1'b0 : 1'b1;
    // tick every cycle so one second fits in a short run
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q       <= 4'h0;
            xtal_tick  <= 1'b0;
            xtal_level <= 1'b0;
        end else begin
            xtal_tick <= 1'b1;
            ph_q      <= ph_q + 4'h1;
            if (ph_q == 4'hF) begin
                xtal_level <= ~xtal_level;
            end
        end
    end
endmodule // rtcai_host_model

// ### tb/rtc_alarm_periodic_irq_tb.sv
// bench of the alarm, periodic and clock-output block, driven through its register port
// assumes rtcai_regs.svh on the include path and rtcai_pkg compiled first
`timescale 1ns/1ps
`include "rtcai_regs.svh"
module rtc_alarm_periodic_irq_tb;
    import rtcai_pkg::*;
    logic       sys_clk = 1'b0;   // 50 MHz
    logic       rst_n   = 1'b0;   // held low at start
    logic [3:0] addr    = 4'h0;   // register address
    logic [7:0] wdata   = 8'h00;  // write data
    logic       wr = 1'b0, rd = 1'b0;
    logic [7:0] rdata;            // read data
    logic       xtal_tick, xtal_level, sec_write = 1'b0, minute_tick = 1'b0, gate = 1'b1;
    logic [2:0] weekday = 3'h2;   // current time
    logic [7:0] hour = 8'h07, minute = 8'h30;
    logic [6:0] w_days = 7'h01;   // weekly mask, misses weekday first
    logic [7:0] dal_h = 8'h00, dal_m = 8'h00;
    logic       second_inc, p_n, p_oe, s_n, s_oe, c_n, c_oe, ck_out;
    logic       prim_pin, sec_pin, shr_pin;
    int         failures = 0, checks_done = 0, n;
    logic [7:0] v;
    always #10 sys_clk = ~sys_clk;
    rtcai_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .xtal_tick(xtal_tick), .xtal_level(xtal_level), .trim_tick(1'b0),
        .sec_write(sec_write), .minute_tick(minute_tick), .weekday(weekday), .hour(hour),
        .minute(minute), .second(8'h00), .day(8'h01), .walarm_weekdays(w_days),
        .walarm_hour(hour), .walarm_minute(minute), .dalarm_hour(dal_h), .dalarm_minute(dal_m),
        .clock_out_gate_pin(gate), .second_inc(second_inc), .primary_irq_n(p_n),
        .primary_irq_oe(p_oe), .secondary_irq_n(s_n), .secondary_irq_oe(s_oe),
        .shared_irq_n(c_n), .shared_irq_oe(c_oe), .crystal_clock_output(ck_out));
    rtcai_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .prim_oe(p_oe), .sec_oe(s_oe),
        .shr_oe(c_oe), .xtal_tick(xtal_tick), .xtal_level(xtal_level), .prim_pin(prim_pin),
        .sec_pin(sec_pin), .shr_pin(shr_pin));
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    // data stand from the cycle after the strobe until the next read
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic tick_min();
        @(posedge sys_clk);
        minute_tick <= 1'b1;
        @(posedge sys_clk);
        minute_tick <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // one-cycle second counter write from the time-keeping side
    task automatic sec_wr();
        @(posedge sys_clk);
        sec_write <= 1'b1;
        @(posedge sys_clk);
        sec_write <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // or of the clock output over 80 cycles, sampled mid-cycle where it is settled
    task automatic watch_ck(output logic [7:0] seen);
        seen = 8'h00;
        repeat (80) @(negedge sys_clk) seen = seen | ck_out;
        @(posedge sys_clk);
    endtask
    // bounded wait: which 0 = primary wire, 1 = second_inc
    task automatic wait_for(input int which, input logic val, output int cnt);
        cnt = 0;
        while (((which == 0) ? prim_pin : second_inc) !== val && cnt < 40000) begin
            @(posedge sys_clk);
            #1 cnt++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog sized for the 2 Hz, 1 Hz and level-mode seconds plus slack
    initial begin
        repeat (95000) @(posedge sys_clk);
        failures++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset state and unmapped place
        rd_reg(`RTCAI_ADDR_CTRL, v);  chk(v, `RTCAI_CTRL_RESET);
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, `RTCAI_FLAGS_RESET);
        rd_reg(4'h5, v); chk(v, 8'h00);
        chk({prim_pin, sec_pin, shr_pin}, 8'h07);
        chk({p_n, s_n, c_n}, 8'h07);
        $display("test reset done");
        // daily alarm programmed onto the current time while disabled
        wr_reg(`RTCAI_ADDR_CTRL, 8'h00);
        dal_h <= hour;
        dal_m <= minute;
        wr_reg(`RTCAI_ADDR_CTRL, 8'h40);
        repeat (3) @(posedge sys_clk);
        chk(prim_pin, 1'b1);
        weekday <= 3'h5;
        tick_min();
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h01);
        chk({prim_pin, sec_pin, shr_pin}, 8'h02);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h07);
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h01);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h00);
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h00);
        chk({prim_pin, shr_pin}, 8'h03);
        rd_reg(`RTCAI_ADDR_CTRL, v); chk(v, 8'h40);
        tick_min();
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h01);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h00);
        $display("test daily done");
        // weekly alarm: day mask miss, then hit; daily disabled
        wr_reg(`RTCAI_ADDR_CTRL, 8'h80);
        tick_min();
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h00);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h00);
        w_days <= 7'h20;
        wr_reg(`RTCAI_ADDR_CTRL, 8'h80);
        tick_min();
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h02);
        chk({prim_pin, sec_pin, shr_pin}, 8'h04);
        chk({p_n, s_n, c_n}, 8'h04);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h00);
        #1 chk(sec_pin, 1'b1);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h00);
        tick_min();
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h00);
        $display("test weekly done");
        // fixed codes
        wr_reg(`RTCAI_ADDR_CTRL, 8'h01);
        #1 chk(prim_pin, 1'b0);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h00);
        #1 chk(prim_pin, 1'b1);
        // 2 Hz and 1 Hz pulses, each restarted by a second write
        // 2 Hz pulse: a quarter second low, then a quarter second high
        wr_reg(`RTCAI_ADDR_CTRL, 8'h02);
        sec_wr();
        chk(prim_pin, 1'b0);
        wait_for(0, 1'b1, n);
        chk(n > 8185 && n < 8195, 1'b1);
        wait_for(0, 1'b0, n);
        chk(n > 8188 && n < 8196, 1'b1);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h03);
        sec_wr();
        chk(prim_pin, 1'b0);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        chk(n > 16380 && n < 16390, 1'b1);
        wait_for(1, 1'b1, n);
        chk(n >= `RTCAI_INC_DELAY_CYC - 2 && n <= `RTCAI_INC_DELAY_CYC + 2, 1'b1);
        $display("test pulse done");
        // level mode once per second
        wr_reg(`RTCAI_ADDR_CTRL, 8'h04);
        wait_for(1, 1'b1, n);
        chk(n < 40000, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 chk(prim_pin, 1'b0);
        repeat (10) @(posedge sys_clk);
        rd_reg(`RTCAI_ADDR_FLAGS, v); chk(v, 8'h04);
        chk(prim_pin, 1'b0);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h00);
        #1 chk(prim_pin, 1'b1);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h00);
        $display("test level done");
        // clock output gating
        // runs from reset, both disable bits being zero
        watch_ck(v);
        chk(v, 8'h01);
        gate <= 1'b0;
        // a pulse in flight finishes before the gate closes
        repeat (40) @(posedge sys_clk);
        watch_ck(v);
        chk(v, 8'h00);
        gate <= 1'b1;
        watch_ck(v);
        chk(v, 8'h01);
        wr_reg(`RTCAI_ADDR_CTRL, 8'h10);
        watch_ck(v);
        chk(v, 8'h01);
        wr_reg(`RTCAI_ADDR_FLAGS, 8'h08);
        repeat (40) @(posedge sys_clk);
        watch_ck(v);
        chk(v, 8'h00);
        $display("test clock out done");
        summarize();
    end
endmodule // rtc_alarm_periodic_irq_tb
